// ===== shared/iscs_pkg.sv
// package: register map, field layout, reset values and vector types for the interrupt source control block
package iscs_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] OFS_STATUS = 8'h30;
	localparam logic [7:0] OFS_TIMER0 = 8'h32;
	localparam logic [7:0] OFS_DMA0 = 8'h34;
	localparam logic [7:0] OFS_DMA1 = 8'h36;
	localparam logic [7:0] OFS_EXT0 = 8'h38;
	localparam logic [7:0] OFS_EXT1 = 8'h3A;
	localparam logic [7:0] OFS_EXT2 = 8'h3C;
	localparam logic [7:0] OFS_EXT3 = 8'h3E;
	localparam logic [7:0] OFS_REQUEST = 8'h2E;
	localparam logic [7:0] OFS_MASKVIEW = 8'h28;
	localparam logic [7:0] OFS_DMASEL = 8'h40;
	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int BIT_NESTED = 6;
	localparam int BIT_CASCADE = 5;
	localparam int BIT_LEVEL = 4;
	localparam int BIT_MASK = 3;
	localparam int BIT_HALT = 15;
	localparam logic [15:0] CTRL_RESET = 16'h000F;
	localparam logic [2:0] PRIO_NONE = 3'h7;
	// ****************************************
	// vector types per source, index order below
	// ****************************************
	localparam int NSRC = 9;
	localparam int SRC_T0 = 0;
	localparam int SRC_T1 = 1;
	localparam int SRC_T2 = 2;
	localparam int SRC_D0 = 3;
	localparam int SRC_D1 = 4;
	localparam int SRC_E0 = 5;
	localparam int SRC_E1 = 6;
	localparam int SRC_E2 = 7;
	localparam int SRC_E3 = 8;
	localparam logic [7:0] VEC_T0 = 8'h08;
	localparam logic [7:0] VEC_T1 = 8'h12;
	localparam logic [7:0] VEC_T2 = 8'h13;
	localparam logic [7:0] VEC_D0 = 8'h0A;
	localparam logic [7:0] VEC_D1 = 8'h0B;
	localparam logic [7:0] VEC_E0 = 8'h0C;
	localparam logic [7:0] VEC_E1 = 8'h0D;
	localparam logic [7:0] VEC_E2 = 8'h0E;
	localparam logic [7:0] VEC_E3 = 8'h0F;
	// register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} iscs_bus_t;
	// winning request
	typedef struct packed {
		logic valid;
		logic [7:0] vector;
		logic [2:0] prio;
	} iscs_win_t;
endpackage

// ===== rtl/iscs_detect.sv
// module: one request input with level or rising-edge detection and a pending latch
`timescale 1ns/1ps
module iscs_detect (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_in,
	input wire logic level_sel,
	input wire logic ack,
	output logic pending
);
	logic prev_q;
	logic edge_q;
	wire rise = req_in & ~prev_q;
	// level: pin itself; edge: latched until acknowledged
	assign pending = level_sel ? req_in : edge_q;
	// edge latch, set wins over acknowledge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev_q <= 1'b0;
			edge_q <= 1'b0;
		end else begin
			prev_q <= req_in;
			edge_q <= rise | (edge_q & ~ack);
		end
	end
endmodule

// ===== rtl/iscs_top.sv
// module: interrupt source control and status registers with priority selection
`timescale 1ns/1ps
module iscs_top (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic [7:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic SLAVE_MODE,
	input wire logic [3:0] EXT_REQUEST_IN,
	output logic [1:0] CASCADE_ACK_OUT,
	output logic [1:0] CASCADE_ACK_OE,
	input wire logic [1:0] CASCADE_ACK_STROBE,
	input wire logic [2:0] TIMER_EVENT,
	input wire logic [1:0] DMA_PIN_IN,
	input wire logic [1:0] DMA_DONE,
	output logic [1:0] DMA_REQUEST,
	input wire logic NMI_EVENT,
	input wire logic INTERRUPT_RETURN_INSTR_EXEC,
	output logic DMA_HALT,
	input wire logic ACK_VALID,
	input wire logic [3:0] ACK_SRC,
	output logic IRQ_VALID,
	output logic [7:0] IRQ_VECTOR,
	output logic [2:0] IRQ_PRIO,
	output logic [1:0] NESTED_EN
);
	// ****************************************
	// bus decode
	// ****************************************
	iscs_pkg::iscs_bus_t bus;
	assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
	wire hit_status = bus.addr == iscs_pkg::OFS_STATUS;
	wire hit_t0 = bus.addr == iscs_pkg::OFS_TIMER0;
	wire hit_d0 = bus.addr == iscs_pkg::OFS_DMA0;
	wire hit_d1 = bus.addr == iscs_pkg::OFS_DMA1;
	wire hit_e0 = bus.addr == iscs_pkg::OFS_EXT0;
	wire hit_e1 = bus.addr == iscs_pkg::OFS_EXT1;
	wire hit_e2 = bus.addr == iscs_pkg::OFS_EXT2;
	wire hit_e3 = bus.addr == iscs_pkg::OFS_EXT3;
	wire hit_req = bus.addr == iscs_pkg::OFS_REQUEST;
	wire hit_mv = bus.addr == iscs_pkg::OFS_MASKVIEW;
	wire hit_sel = bus.addr == iscs_pkg::OFS_DMASEL;

	// ****************************************
	// control registers
	// ****************************************
	logic [6:0] tgrp_q; // shared timer control, master mode
	logic [6:0] t1s_q; // slave timer 1 control
	logic [6:0] t2s_q; // slave timer 2 control
	logic [6:0] t0s_q; // slave timer 0 control
	logic [6:0] d0_q;
	logic [6:0] d1_q;
	logic [6:0] e0_q;
	logic [6:0] e1_q;
	logic [6:0] e2_q;
	logic [6:0] e3_q;
	logic [1:0] dsel_q; // 1: dma pin is an interrupt input
	logic halt_q;
	logic [2:0] tpend_q;
	logic [15:0] rdata_q;

	// timer 1/2 offsets share with ext 0/1 in slave mode
	wire wr_t0 = bus.wr & hit_t0;
	wire wr_e0m = bus.wr & hit_e0 & ~SLAVE_MODE;
	wire wr_e1m = bus.wr & hit_e1 & ~SLAVE_MODE;
	wire wr_t1s = bus.wr & hit_e0 & SLAVE_MODE;
	wire wr_t2s = bus.wr & hit_e1 & SLAVE_MODE;
	// mask view writes: bit layout timer0, -, d0, d1, e0..e3 at 4..7
	wire wr_mv = bus.wr & hit_mv;
	wire [6:0] w_full = bus.wdata[6:0];
	wire [6:0] w_lvl = {2'b00, bus.wdata[4:0]};
	wire [6:0] w_mp = {3'b000, bus.wdata[3:0]};

	// next values with mask mirror applied
	function automatic logic [6:0] nxt(input logic [6:0] cur, input logic wr, input logic [6:0] wv,
		input logic mw, input logic mv);
		logic [6:0] r;
		r = wr ? wv : cur;
		if (mw) begin
			r[iscs_pkg::BIT_MASK] = mv;
		end
		return r;
	endfunction

	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			// every control comes up masked at lowest priority
			tgrp_q <= iscs_pkg::CTRL_RESET[6:0];
			t0s_q <= iscs_pkg::CTRL_RESET[6:0];
			t1s_q <= iscs_pkg::CTRL_RESET[6:0];
			t2s_q <= iscs_pkg::CTRL_RESET[6:0];
			d0_q <= iscs_pkg::CTRL_RESET[6:0];
			d1_q <= iscs_pkg::CTRL_RESET[6:0];
			e0_q <= iscs_pkg::CTRL_RESET[6:0];
			e1_q <= iscs_pkg::CTRL_RESET[6:0];
			e2_q <= iscs_pkg::CTRL_RESET[6:0];
			e3_q <= iscs_pkg::CTRL_RESET[6:0];
			dsel_q <= 2'h0;
		end else begin
			tgrp_q <= nxt(tgrp_q, wr_t0 & ~SLAVE_MODE, w_mp, wr_mv & ~SLAVE_MODE, bus.wdata[0]);
			t0s_q <= nxt(t0s_q, wr_t0 & SLAVE_MODE, w_mp, wr_mv & SLAVE_MODE, bus.wdata[0]);
			t1s_q <= nxt(t1s_q, wr_t1s, w_mp, wr_mv & SLAVE_MODE, bus.wdata[4]);
			t2s_q <= nxt(t2s_q, wr_t2s, w_mp, wr_mv & SLAVE_MODE, bus.wdata[5]);
			// dma controls same address in either mode
			d0_q <= nxt(d0_q, bus.wr & hit_d0, w_mp, wr_mv, bus.wdata[2]);
			d1_q <= nxt(d1_q, bus.wr & hit_d1, w_mp, wr_mv, bus.wdata[3]);
			e0_q <= nxt(e0_q, wr_e0m, w_full, wr_mv & ~SLAVE_MODE, bus.wdata[4]);
			e1_q <= nxt(e1_q, wr_e1m, w_full, wr_mv & ~SLAVE_MODE, bus.wdata[5]);
			e2_q <= nxt(e2_q, bus.wr & hit_e2, w_lvl, wr_mv & ~SLAVE_MODE, bus.wdata[6]);
			e3_q <= nxt(e3_q, bus.wr & hit_e3, w_lvl, wr_mv & ~SLAVE_MODE, bus.wdata[7]);
			if (bus.wr & hit_sel) begin
				dsel_q <= bus.wdata[1:0];
			end
		end
	end

	// ****************************************
	// request detection
	// ****************************************
	wire cascade_any = e0_q[iscs_pkg::BIT_CASCADE] | e1_q[iscs_pkg::BIT_CASCADE];
	wire [3:0] ext_lvl = {e3_q[iscs_pkg::BIT_LEVEL], e2_q[iscs_pkg::BIT_LEVEL],
		e1_q[iscs_pkg::BIT_LEVEL], e0_q[iscs_pkg::BIT_LEVEL]};
	// pins 2/3 stop being requests in cascade mode
	wire [3:0] ext_in = {EXT_REQUEST_IN[3] & ~cascade_any, EXT_REQUEST_IN[2] & ~cascade_any,
		EXT_REQUEST_IN[1:0]};
	// shared pin feeds interrupt or dma side
	wire [1:0] dma_irq_in = DMA_PIN_IN & dsel_q;
	wire [1:0] dma_evt = dma_irq_in | DMA_DONE;
	logic [8:0] ack_vec;
	logic [3:0] ext_pend;
	logic [1:0] dma_pend;
	assign ack_vec = ACK_VALID ? 9'(9'h001 << ACK_SRC) : 9'h000;

	genvar gi;
	// one detector per external pin, level or edge
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ext
			iscs_detect u_det (
				.clk(CORE_CLK),
				.rst_n(RESET_N),
				.req_in(ext_in[gi]),
				.level_sel(ext_lvl[gi]),
				.ack(ack_vec[iscs_pkg::SRC_E0 + gi]),
				.pending(ext_pend[gi])
			);
		end
		for (gi = 0; gi < 2; gi++) begin : g_dma
			iscs_detect u_det (
				.clk(CORE_CLK),
				.rst_n(RESET_N),
				.req_in(dma_evt[gi]),
				.level_sel(1'b0),
				.ack(ack_vec[iscs_pkg::SRC_D0 + gi]),
				.pending(dma_pend[gi])
			);
		end
	endgenerate

	// ****************************************
	// status register: timer pending and dma halt
	// ****************************************
	wire wr_status = bus.wr & hit_status;
	wire [2:0] t_ack = ack_vec[2:0];
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			tpend_q <= 3'h0;
			halt_q <= 1'b0;
		end else begin
			// event set wins over ack or software clear
			tpend_q <= TIMER_EVENT | (tpend_q & ~t_ack & ~(wr_status ? ~bus.wdata[2:0] : 3'h0));
			// nmi sets, return clears, software may write
			if (NMI_EVENT) begin
				halt_q <= 1'b1;
			end else if (INTERRUPT_RETURN_INSTR_EXEC) begin
				halt_q <= 1'b0;
			end else if (wr_status) begin
				halt_q <= bus.wdata[iscs_pkg::BIT_HALT];
			end
		end
	end

	// ****************************************
	// per-source mask, priority, vector
	// ****************************************
	logic [8:0] src_pend;
	logic [8:0] src_mask;
	logic [8:0][2:0] src_prio;
	logic [8:0][7:0] src_vec;
	wire [6:0] tc0 = SLAVE_MODE ? t0s_q : tgrp_q;
	wire [6:0] tc1 = SLAVE_MODE ? t1s_q : tgrp_q;
	wire [6:0] tc2 = SLAVE_MODE ? t2s_q : tgrp_q;
	assign src_pend = {ext_pend, dma_pend, tpend_q};
	assign src_mask = {e3_q[3], e2_q[3], e1_q[3], e0_q[3], d1_q[3], d0_q[3], tc2[3], tc1[3], tc0[3]};
	assign src_prio = {e3_q[2:0], e2_q[2:0], e1_q[2:0], e0_q[2:0], d1_q[2:0], d0_q[2:0],
		tc2[2:0], tc1[2:0], tc0[2:0]};
	// fixed vector types
	assign src_vec = {iscs_pkg::VEC_E3, iscs_pkg::VEC_E2, iscs_pkg::VEC_E1, iscs_pkg::VEC_E0,
		iscs_pkg::VEC_D1, iscs_pkg::VEC_D0, iscs_pkg::VEC_T2, iscs_pkg::VEC_T1, iscs_pkg::VEC_T0};
	wire [8:0] src_live = src_pend & ~src_mask;

	// lowest priority number wins, lowest index on tie
	iscs_pkg::iscs_win_t win;
	always_comb begin
		win = '{valid: 1'b0, vector: 8'h00, prio: iscs_pkg::PRIO_NONE};
		for (int i = 0; i < iscs_pkg::NSRC; i++) begin
			if (src_live[i] && (!win.valid || src_prio[i] < win.prio)) begin
				win = '{valid: 1'b1, vector: src_vec[i], prio: src_prio[i]};
			end
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	wire [15:0] rd_status = {halt_q, 12'h000, tpend_q};
	// ext 0..3 at bits 4..7, same layout as the mask view
	wire [15:0] rd_req_m = {8'h00, ext_pend, dma_pend, 1'b0, |tpend_q};
	wire [15:0] rd_req_s = {10'h000, tpend_q[2:1], dma_pend, 1'b0, tpend_q[0]};
	wire [15:0] rd_mv_m = {8'h00, src_mask[8:5], src_mask[4:3], 1'b0, tgrp_q[3]};
	wire [15:0] rd_mv_s = {10'h000, src_mask[2:1], src_mask[4:3], 1'b0, src_mask[0]};
	wire [15:0] rd_t0 = {9'h000, tc0};
	wire [15:0] rd_e0 = {9'h000, SLAVE_MODE ? t1s_q : e0_q};
	wire [15:0] rd_e1 = {9'h000, SLAVE_MODE ? t2s_q : e1_q};
	wire [15:0] rd_mux =
		hit_status ? rd_status :
		hit_t0 ? rd_t0 :
		hit_d0 ? {9'h000, d0_q} :
		hit_d1 ? {9'h000, d1_q} :
		hit_e0 ? rd_e0 :
		hit_e1 ? rd_e1 :
		hit_e2 ? {9'h000, e2_q} :
		hit_e3 ? {9'h000, e3_q} :
		hit_req ? (SLAVE_MODE ? rd_req_s : rd_req_m) :
		hit_mv ? (SLAVE_MODE ? rd_mv_s : rd_mv_m) :
		hit_sel ? {14'h0000, dsel_q} : 16'h0000;

	// ****************************************
	// registered outputs
	// ****************************************
	always_ff @(posedge CORE_CLK) begin
		if (!RESET_N) begin
			rdata_q <= 16'h0000;
			RDATA <= 16'h0000;
			IRQ_VALID <= 1'b0;
			IRQ_VECTOR <= 8'h00;
			IRQ_PRIO <= iscs_pkg::PRIO_NONE;
			CASCADE_ACK_OUT <= 2'h0;
			CASCADE_ACK_OE <= 2'h0;
			DMA_REQUEST <= 2'h0;
			DMA_HALT <= 1'b0;
			NESTED_EN <= 2'h0;
		end else begin
			RDATA <= bus.rd ? rd_mux : 16'h0000;
			IRQ_VALID <= win.valid;
			IRQ_VECTOR <= win.vector;
			IRQ_PRIO <= win.prio;
			// pins 2/3 drive acknowledge toward cascaded slaves
			CASCADE_ACK_OE <= {2{cascade_any}};
			CASCADE_ACK_OUT <= cascade_any ? CASCADE_ACK_STROBE : 2'h0;
			// dma requests stop while halted
			DMA_REQUEST <= DMA_PIN_IN & ~dsel_q & {2{~halt_q}};
			DMA_HALT <= halt_q;
			NESTED_EN <= {e1_q[iscs_pkg::BIT_NESTED], e0_q[iscs_pkg::BIT_NESTED]};
		end
	end
endmodule

// ===== tb/iscs_top_assertions.sv
// checker: port timing relations of the interrupt source control block
`timescale 1ns/1ps
module iscs_top_checker (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	input wire logic [1:0] CASCADE_ACK_OUT,
	input wire logic [1:0] CASCADE_ACK_OE,
	input wire logic [1:0] CASCADE_ACK_STROBE,
	input wire logic [1:0] DMA_REQUEST,
	input wire logic NMI_EVENT,
	input wire logic INTERRUPT_RETURN_INSTR_EXEC,
	input wire logic DMA_HALT,
	input wire logic IRQ_VALID,
	input wire logic [7:0] IRQ_VECTOR,
	input wire logic [1:0] NESTED_EN
);
	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	a_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000) else $error("read data outside slot");
	a_vector_legal: assert property (IRQ_VALID |-> IRQ_VECTOR inside
		{8'h08, 8'h12, 8'h13, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F}) else $error("illegal vector");
	a_halt_on_nmi: assert property (NMI_EVENT |-> ##[1:2] DMA_HALT) else $error("halt not set");
	a_halt_on_return: assert property (
		INTERRUPT_RETURN_INSTR_EXEC && !NMI_EVENT ##1 !NMI_EVENT |-> ##[0:1] !DMA_HALT) else $error("halt not cleared");
	a_halt_blocks_dma: assert property (
		NMI_EVENT ##1 !INTERRUPT_RETURN_INSTR_EXEC [*2] |=> DMA_REQUEST == 2'b00) else $error("dma request while halted");
	a_ack_pins_pair: assert property (CASCADE_ACK_OE[0] == CASCADE_ACK_OE[1]) else $error("ack pins split");
	a_ack_follows: assert property (
		CASCADE_ACK_OE[0] && $past(CASCADE_ACK_OE[0]) |-> CASCADE_ACK_OUT == $past(CASCADE_ACK_STROBE))
		else $error("ack drive wrong");
	a_ack_quiet: assert property (
		!CASCADE_ACK_OE[0] && !$past(CASCADE_ACK_OE[0]) |-> CASCADE_ACK_OUT == 2'b00) else $error("ack driven");
	a_oe_by_write: assert property ($changed(CASCADE_ACK_OE) |-> $past(WR) || $past(WR, 2))
		else $error("cascade enable moved alone");
	a_nested_by_write: assert property ($changed(NESTED_EN) |-> $past(WR) || $past(WR, 2))
		else $error("nested enable moved alone");
	a_masked_at_reset: assert property ($rose(RESET_N) |-> !IRQ_VALID) else $error("request at reset");
	// main scenarios reached
	c_irq: cover property (IRQ_VALID);
	c_halt: cover property (NMI_EVENT ##[1:2] DMA_HALT);
	c_cascade: cover property (CASCADE_ACK_OE[0] && CASCADE_ACK_OUT[0]);
endmodule
bind iscs_top iscs_top_checker u_chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .WR(WR), .RD(RD), .RDATA(RDATA),
	.CASCADE_ACK_OUT(CASCADE_ACK_OUT), .CASCADE_ACK_OE(CASCADE_ACK_OE), .CASCADE_ACK_STROBE(CASCADE_ACK_STROBE),
	.DMA_REQUEST(DMA_REQUEST), .NMI_EVENT(NMI_EVENT), .INTERRUPT_RETURN_INSTR_EXEC(INTERRUPT_RETURN_INSTR_EXEC), .DMA_HALT(DMA_HALT),
	.IRQ_VALID(IRQ_VALID), .IRQ_VECTOR(IRQ_VECTOR), .NESTED_EN(NESTED_EN));

// ===== tb/iscs_ext_src_model.sv
// partner model: external request sources holding each request until acknowledged
`timescale 1ns/1ps
module iscs_ext_src_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] raise,
	input wire logic ack_valid,
	input wire logic [3:0] ack_src,
	output logic [3:0] req
);
	// ****************************************
	// request hold
	// ****************************************
	// line rises on command, falls only on its own acknowledge
	always_ff @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (!rst_n)
				req[i] <= 1'b0;
			else if (raise[i])
				req[i] <= 1'b1;
			else if (ack_valid && ack_src == 4'(5 + i))
				req[i] <= 1'b0;
		end
	end
endmodule

// ===== tb/irq_source_control_status_tb.sv
// testbench: register and request path checks of the interrupt source control block
`timescale 1ns/1ps
module irq_source_control_status_tb;
	logic CORE_CLK = 1'b0, RESET_N = 1'b0, WR = 1'b0, RD = 1'b0, SLAVE_MODE = 1'b0;
	logic [7:0] ADDR = 8'h00, IRQ_VECTOR;
	logic [15:0] WDATA = 16'h0000, RDATA, q;
	logic [13:0] ev = 14'h0000;
	logic [3:0] ACK_SRC = 4'h0, req, pins;
	logic [1:0] dpin = 2'h0, CASCADE_ACK_OUT, CASCADE_ACK_OE, DMA_REQUEST, NESTED_EN;
	logic DMA_HALT, IRQ_VALID;
	logic [2:0] IRQ_PRIO;
	logic [7:0] tvec [3] = '{8'h08, 8'h12, 8'h13};
	int mismatches = 0;
	int n_compared = 0;
	// pins 2 and 3 carry the acknowledge drive while enabled
	assign pins = {CASCADE_ACK_OE[1] ? CASCADE_ACK_OUT[1] : req[3],
		CASCADE_ACK_OE[0] ? CASCADE_ACK_OUT[0] : req[2], req[1:0]};
	iscs_top dut (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.SLAVE_MODE(SLAVE_MODE), .EXT_REQUEST_IN(pins), .CASCADE_ACK_OUT(CASCADE_ACK_OUT), .CASCADE_ACK_OE(CASCADE_ACK_OE),
		.CASCADE_ACK_STROBE(ev[12:11]), .TIMER_EVENT(ev[6:4]), .DMA_PIN_IN(dpin), .DMA_DONE(ev[10:9]),
		.DMA_REQUEST(DMA_REQUEST), .NMI_EVENT(ev[7]), .INTERRUPT_RETURN_INSTR_EXEC(ev[8]), .DMA_HALT(DMA_HALT), .ACK_VALID(ev[13]),
		.ACK_SRC(ACK_SRC), .IRQ_VALID(IRQ_VALID), .IRQ_VECTOR(IRQ_VECTOR), .IRQ_PRIO(IRQ_PRIO), .NESTED_EN(NESTED_EN));
	iscs_ext_src_model src (.clk(CORE_CLK), .rst_n(RESET_N), .raise(ev[3:0]), .ack_valid(ev[13]), .ack_src(ACK_SRC),
		.req(req));
	// ****************************************
	// bus, event and compare tasks
	// ****************************************
	// one strobe cycle; read data taken in the following cycle
	task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge CORE_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= w;
		RD <= !w;
		@(posedge CORE_CLK);
		WR <= 1'b0;
		RD <= 1'b0;
		#1;
		q = RDATA;
	endtask
	// one-cycle event pulses; bit 13 is the acknowledge
	task automatic pulse(input logic [13:0] m, input logic [3:0] s);
		@(posedge CORE_CLK);
		ev <= m;
		ACK_SRC <= s;
		@(posedge CORE_CLK);
		ev <= 14'h0000;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge CORE_CLK);
		#1;
	endtask
	task automatic irq(input logic v, input logic [2:0] p, input logic [7:0] vec);
		settle(4);
		chk("irq", v ? {1'b1, 4'h0, p, vec} : 16'h0000, v ? {IRQ_VALID, 4'h0, IRQ_PRIO, IRQ_VECTOR} : {15'h0, IRQ_VALID});
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		forever #12.5 CORE_CLK = ~CORE_CLK;
	end
	// watchdog cuts a hang short
	initial begin
		repeat (4000) @(posedge CORE_CLK);
		mismatches++;
		summarize();
	end
	initial begin
		repeat (2) @(posedge CORE_CLK);
		RESET_N <= 1'b1;
		for (int i = 1; i < 8; i++) begin
			access(1'b0, 8'h30 + 8'(2 * i), 16'h0000);
			chk("ctrl reset", 16'h000F, q);
		end
		access(1'b1, 8'h50, 16'hFFFF);
		access(1'b0, 8'h50, 16'h0000);
		chk("unmapped", 16'h0000, q);
		$display("done: reset values");
		// edge mode on pins 0/1, level mode on pins 2/3
		for (int i = 0; i < 4; i++) begin
			access(1'b1, 8'h38 + 8'(2 * i), 16'(i) | ((i > 1) ? 16'h0010 : 16'h0000));
			pulse(14'(1 << i), 4'h0);
			irq(1'b1, 3'(i), 8'h0C + 8'(i));
			pulse(14'h2000, 4'(5 + i));
			irq(1'b0, 3'h0, 8'h00);
			access(1'b1, 8'h38 + 8'(2 * i), 16'h000F);
		end
		access(1'b1, 8'h38, 16'h001A);
		pulse(14'h0001, 4'h0);
		irq(1'b0, 3'h0, 8'h00);
		access(1'b0, 8'h28, 16'h0000);
		chk("mask view", 16'h0010, q & 16'h0010);
		access(1'b1, 8'h38, 16'h0012);
		irq(1'b1, 3'h2, 8'h0C);
		access(1'b0, 8'h28, 16'h0000);
		chk("mask view", 16'h0000, q & 16'h0010);
		pulse(14'h2000, 4'h5);
		access(1'b1, 8'h38, 16'h0005);
		access(1'b1, 8'h3A, 16'h0002);
		pulse(14'h0003, 4'h0);
		irq(1'b1, 3'h2, 8'h0D);
		pulse(14'h2000, 4'h6);
		irq(1'b1, 3'h5, 8'h0C);
		pulse(14'h2000, 4'h5);
		$display("done: external sources");
		access(1'b1, 8'h32, 16'h0003);
		for (int t = 0; t < 3; t++) begin
			pulse(14'(16 << t), 4'h0);
			access(1'b0, 8'h30, 16'h0000);
			chk("status", 16'(1 << t), q);
			access(1'b0, 8'h2E, 16'h0000);
			chk("request", 16'h0001, q & 16'h0001);
			irq(1'b1, 3'h3, tvec[t]);
			pulse(14'h2000, 4'(t));
		end
		$display("done: timers");
		access(1'b1, 8'h40, 16'h0000);
		@(posedge CORE_CLK);
		dpin <= 2'h3;
		settle(3);
		chk("dma pins", 16'h0003, {13'h0, DMA_HALT, DMA_REQUEST});
		pulse(14'h0080, 4'h0);
		access(1'b0, 8'h30, 16'h0000);
		chk("status", 16'h8000, q);
		chk("dma pins", 16'h0004, {13'h0, DMA_HALT, DMA_REQUEST});
		pulse(14'h0100, 4'h0);
		settle(3);
		chk("dma pins", 16'h0003, {13'h0, DMA_HALT, DMA_REQUEST});
		access(1'b1, 8'h40, 16'h0003);
		settle(2);
		chk("dma pins", 16'h0000, {13'h0, DMA_HALT, DMA_REQUEST});
		@(posedge CORE_CLK);
		dpin <= 2'h0;
		for (int d = 0; d < 2; d++) begin
			access(1'b1, 8'h34 + 8'(2 * d), 16'h0001);
			pulse(14'(512 << d), 4'h0);
			irq(1'b1, 3'h1, 8'h0A + 8'(d));
			pulse(14'h2000, 4'(3 + d));
		end
		// software halt only with the timer group masked
		access(1'b1, 8'h32, 16'h000F);
		access(1'b1, 8'h30, 16'h8007);
		settle(1);
		chk("soft halt", 16'h0004, {13'h0, DMA_HALT, DMA_REQUEST});
		access(1'b1, 8'h30, 16'h0007);
		settle(1);
		chk("soft halt", 16'h0000, {13'h0, DMA_HALT, DMA_REQUEST});
		$display("done: dma and halt");
		@(posedge CORE_CLK);
		SLAVE_MODE <= 1'b1;
		access(1'b1, 8'h38, 16'h0004);
		access(1'b0, 8'h38, 16'h0000);
		chk("slave ctrl", 16'h0004, q);
		access(1'b0, 8'h34, 16'h0000);
		chk("dma ctrl", 16'h0001, q);
		pulse(14'h0020, 4'h0);
		irq(1'b1, 3'h4, 8'h12);
		pulse(14'h2000, 4'h1);
		access(1'b1, 8'h38, 16'h000F);
		@(posedge CORE_CLK);
		SLAVE_MODE <= 1'b0;
		$display("done: slave mode");
		access(1'b1, 8'h38, 16'h006F);
		settle(2);
		chk("cascade", 16'h0007, {12'h0, NESTED_EN, CASCADE_ACK_OE});
		pulse(14'h0800, 4'h0);
		#1;
		chk("ack out", 16'h0001, {14'h0, CASCADE_ACK_OUT});
		access(1'b1, 8'h38, 16'h000F);
		settle(2);
		chk("cascade", 16'h0000, {12'h0, NESTED_EN, CASCADE_ACK_OE});
		$display("done: cascade");
		summarize();
	end
endmodule
